// ==== rtl/tcf_edge_sync.sv ====
// Three-stage synchroniser with edge detection per capture line
module tcf_edge_sync import tcf_pkg::*; #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Raw pins and edge pulses
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] stable;

  // Synchroniser chain
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  assign stable = ~(s2_q ^ s3_q);

  // Accepted level and edge pulses
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      lvl_q <= '0;
      rise_o <= '0;
      fall_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        rise_o[i] <= stable[i] & s3_q[i] & ~lvl_q[i];
        fall_o[i] <= stable[i] & ~s3_q[i] & lvl_q[i];
        if (stable[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule // tcf_edge_sync

// ==== rtl/tcf_periodic_div.sv ====
// Free-running periodic divider, independent of the counter prescaler
module tcf_periodic_div import tcf_pkg::*; #(
  parameter int BASE_LOG2 = PER_BASE_LOG2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Rate select and timeout pulse
  input wire logic [1:0] rate_i,
  output logic timeout_o
);
  localparam int DW = BASE_LOG2 + 4;
  logic [DW-1:0] div_q;
  logic [DW-1:0] end_mask;

  // Ones in the low BASE_LOG2 + rate bits mark the end of a period
  assign end_mask = {DW{1'b1}} >> (DW - BASE_LOG2 - int'(rate_i));

  // Divider only stops under reset; a timeout never restarts it, so periods stay aligned to the count from reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      timeout_o <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      timeout_o <= ((div_q & end_mask) == end_mask);
    end
  end
endmodule // tcf_periodic_div

// ==== rtl/tcf_pkg.sv ====
package tcf_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_PIN_ACT = 8'h00;
  localparam logic [7:0] OFS_IRQ_EN1 = 8'h04;
  localparam logic [7:0] OFS_FLAGS1 = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN2 = 8'h0C;
  localparam logic [7:0] OFS_FLAGS2 = 8'h10;
  localparam logic [7:0] OFS_ACC_CTRL = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  // ****************************************
  // Field positions and masks
  // ****************************************
  localparam int B_OVF = 7;
  localparam int B_PER = 6;
  localparam int B_ACC_OVF = 5;
  localparam int B_ACC_EDGE = 4;
  localparam int B_SHARED_SEL = 2;
  localparam int B_SHARED = 3;
  localparam logic [7:0] MASK2_IMPL = 8'hF3;
  localparam logic [7:0] FLAG2_IMPL = 8'hF0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int PRESC_WIN_CYC = 64;
  localparam int PER_BASE_LOG2 = 13;
  localparam logic [3:0] DIV1_END = 4'h0;
  localparam logic [3:0] DIV4_END = 4'h3;
  localparam logic [3:0] DIV8_END = 4'h7;
  localparam logic [3:0] DIV16_END = 4'hF;
  // Pin action encodings
  typedef enum logic [1:0] {
    ACT_DETACH = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_LOW = 2'b10,
    ACT_HIGH = 2'b11
  } tcf_act_e;
endpackage

// ==== rtl/tcf_timer.sv ====
// Added by the designer: the address map and register access over Wishbone.
module tcf_timer import tcf_pkg::*; #(
  parameter int PER_LOG2 = PER_BASE_LOG2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Mode and compare values from neighbouring logic
  input wire logic special_mode_i,
  input wire logic [15:0] cmp1_val_i,
  input wire logic [15:0] cmp2_val_i,
  input wire logic [15:0] cmp3_val_i,
  input wire logic [15:0] cmp4_val_i,
  input wire logic [15:0] cmp5_val_i,
  // Capture pins and edge selects (channel 1 in bits 7:6)
  input wire logic [3:0] cap_pin_i,
  input wire logic [7:0] cap_edge_sel_i,
  // Accumulator events from neighbouring logic
  input wire logic accum_ovf_evt_i,
  input wire logic accum_edge_evt_i,
  // Compare pins, channel 2 in bit 3 down to channel 5 in bit 0
  output logic [3:0] cmp_pin_o,
  output logic [3:0] cmp_pin_oe_o,
  // Counter, status and accumulator control
  output logic [15:0] count_o,
  output logic cmp1_match_o,
  output logic [3:0] accum_ctrl_o,
  output logic porta3_dir_o,
  output logic irq_o
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] pin_act_q, irq_en1_q, flags1_q, irq_en2_q, flags2_q, acc_ctrl_q;
  logic [15:0] cnt_q;
  logic [3:0] presc_q;
  logic cnt_new_q;
  logic [6:0] win_q;
  logic presc_lock_q;
  logic [7:0] set1, clr1, set2, clr2;
  logic [4:0] match;
  logic cnt_tick, shared_sel;
  logic [3:0] rise, fall, cap_evt;
  logic per_timeout;
  logic req, wr_stb;
  logic [7:0] rd_byte;

  // ****************************************
  // Helper functions
  // ****************************************
  // Prescale end count for each select code
  function automatic logic [3:0] presc_end(input logic [1:0] sel);
    unique case (sel)
      2'b00: presc_end = DIV1_END;
      2'b01: presc_end = DIV4_END;
      2'b10: presc_end = DIV8_END;
      2'b11: presc_end = DIV16_END;
    endcase
  endfunction

  // Pin level after a match for one action field
  function automatic logic pin_next(input logic [1:0] act, input logic cur);
    unique case (tcf_act_e'(act))
      ACT_DETACH: pin_next = cur;
      ACT_TOGGLE: pin_next = ~cur;
      ACT_LOW: pin_next = 1'b0;
      ACT_HIGH: pin_next = 1'b1;
    endcase
  endfunction

  // Edge select decode: 01 rising, 10 falling, 11 any, 00 off
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = (sel[0] & r) | (sel[1] & f);
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  assign req = wb_cyc_i & wb_stb_i;
  // Write takes effect at the edge where the master sees ack
  assign wr_stb = req & wb_ack_o & wb_we_i & wb_sel_i[0];

  // Read mux, unimplemented bits and unmapped addresses read zero
  always_comb begin
    unique case (wb_adr_i)
      OFS_PIN_ACT: rd_byte = pin_act_q;
      OFS_IRQ_EN1: rd_byte = irq_en1_q;
      OFS_FLAGS1: rd_byte = flags1_q;
      OFS_IRQ_EN2: rd_byte = irq_en2_q & MASK2_IMPL;
      OFS_FLAGS2: rd_byte = flags2_q & FLAG2_IMPL;
      OFS_ACC_CTRL: rd_byte = acc_ctrl_q;
      OFS_COUNT: rd_byte = cnt_q[7:0];
      default: rd_byte = RST_BYTE;
    endcase
  end

  // Ack one cycle after request, drop it the cycle after
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        wb_dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Plain read-write control bytes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pin_act_q <= RST_BYTE;
      irq_en1_q <= RST_BYTE;
      acc_ctrl_q <= RST_BYTE;
    end else if (wr_stb) begin
      if (wb_adr_i == OFS_PIN_ACT) begin
        pin_act_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == OFS_IRQ_EN1) begin
        irq_en1_q <= wb_dat_i[7:0];
      end
      if (wb_adr_i == OFS_ACC_CTRL) begin
        acc_ctrl_q <= wb_dat_i[7:0];
      end
    end
  end

  // Second mask; prescale bits are write-once inside the window, writable at any time in special mode
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_en2_q <= RST_BYTE;
    end else if (wr_stb && wb_adr_i == OFS_IRQ_EN2) begin
      irq_en2_q[7:2] <= wb_dat_i[7:2] & MASK2_IMPL[7:2];
      if (special_mode_i || !presc_lock_q) begin
        irq_en2_q[1:0] <= wb_dat_i[1:0];
      end
    end
  end

  // Prescale lock after first write or once the window closes
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      win_q <= '0;
      presc_lock_q <= 1'b0;
    end else begin
      if (win_q != 7'(PRESC_WIN_CYC)) begin
        win_q <= win_q + 7'h01;
      end
      if (win_q == 7'(PRESC_WIN_CYC - 1)) begin
        presc_lock_q <= 1'b1;
      end
      if (wr_stb && wb_adr_i == OFS_IRQ_EN2) begin
        presc_lock_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Free-running counter
  // ****************************************
  // Tick when the prescaler reaches the end count of the chosen divisor
  assign cnt_tick = (presc_q == presc_end(irq_en2_q[1:0]));

  // Prescaler, counter and fresh-value marker
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      presc_q <= '0;
      cnt_q <= RST_COUNT;
      cnt_new_q <= 1'b1;
    end else begin
      presc_q <= cnt_tick ? 4'h0 : presc_q + 4'h1;
      cnt_new_q <= cnt_tick;
      if (cnt_tick) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ****************************************
  // Compare and capture events
  // ****************************************
  // Select bit set hands the shared register to capture four
  // Compare five and its pin drive are idle while it is set
  assign shared_sel = acc_ctrl_q[B_SHARED_SEL];

  // Match once per counter value, checked every cycle
  always_comb begin
    match[0] = cnt_new_q & (cnt_q == cmp1_val_i);
    match[1] = cnt_new_q & (cnt_q == cmp2_val_i);
    match[2] = cnt_new_q & (cnt_q == cmp3_val_i);
    match[3] = cnt_new_q & (cnt_q == cmp4_val_i);
    match[4] = cnt_new_q & (cnt_q == cmp5_val_i) & ~shared_sel;
  end

  tcf_edge_sync #(
    .W(4)
  ) u_cap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(cap_pin_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Capture events: bits 3..1 are channels 1..3, bit 0 channel 4
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cap_evt[i] = edge_hit(cap_edge_sel_i[2*i +: 2], rise[i], fall[i]);
    end
  end

  // First flag set and clear vectors
  always_comb begin
    set1 = {match[0], match[1], match[2], match[3], 4'h0};
    set1[B_SHARED] = shared_sel ? cap_evt[0] : match[4];
    set1[2:0] = cap_evt[3:1];
    clr1 = (wr_stb && wb_adr_i == OFS_FLAGS1) ? wb_dat_i[7:0] : 8'h00;
  end

  // ****************************************
  // Periodic divider
  // ****************************************
  tcf_periodic_div #(
    .BASE_LOG2(PER_LOG2)
  ) u_periodic (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .rate_i(acc_ctrl_q[1:0]),
    .timeout_o(per_timeout)
  );

  // Second flag set and clear vectors
  always_comb begin
    set2 = 8'h00;
    set2[B_OVF] = cnt_tick & (cnt_q == COUNT_MAX);
    set2[B_PER] = per_timeout;
    set2[B_ACC_OVF] = accum_ovf_evt_i;
    set2[B_ACC_EDGE] = accum_edge_evt_i;
    clr2 = 8'h00;
    if (wr_stb && wb_adr_i == OFS_FLAGS2) begin
      clr2 = wb_dat_i[7:0] & FLAG2_IMPL;
    end
  end

  // ****************************************
  // Flags, set wins over clear
  // ****************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flags1_q <= RST_BYTE;
      flags2_q <= RST_BYTE;
    end else begin
      flags1_q <= (flags1_q & ~clr1) | set1;
      flags2_q <= ((flags2_q & ~clr2) | set2) & FLAG2_IMPL;
    end
  end

  // ****************************************
  // Compare pins
  // ****************************************
  // Act on every channel 2 to 5 match regardless of flag state
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cmp_pin_o <= '0;
      cmp_pin_oe_o <= '0;
    end else begin
      for (int c = 0; c < 4; c++) begin
        cmp_pin_oe_o[3-c] <= (pin_act_q[7-2*c -: 2] != ACT_DETACH);
        if (match[c+1]) begin
          cmp_pin_o[3-c] <= pin_next(pin_act_q[7-2*c -: 2], cmp_pin_o[3-c]);
        end
      end
      if (shared_sel) begin
        cmp_pin_oe_o[0] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Interrupt request and status outputs
  // ****************************************
  // Masks line up bit for bit with their flags
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (|(irq_en1_q & flags1_q))
        | (|(irq_en2_q[7:4] & flags2_q[7:4]));
    end
  end

  // Registered copies of counter, channel one match and control bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      count_o <= RST_COUNT;
      cmp1_match_o <= 1'b0;
      accum_ctrl_o <= '0;
      porta3_dir_o <= 1'b0;
    end else begin
      count_o <= cnt_q;
      cmp1_match_o <= match[0];
      accum_ctrl_o <= acc_ctrl_q[7:4];
      porta3_dir_o <= acc_ctrl_q[3];
    end
  end
endmodule // tcf_timer

// ==== verification/tcf_pin_model.sv ====
module tcf_pin_model (
  // Clock
  input wire logic ref_clk_i,
  // Capture pins driven from requested levels
  input wire logic [3:0] lvl_i,
  output logic [3:0] cap_pin_o,
  // Compare pin watch
  input wire logic [3:0] cmp_pin_i,
  output logic [7:0] tog_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q = 1'b0;
  initial cap_pin_o = 4'h0;
  initial tog_cnt_o = 8'h00;
  // Pins move only on the clock, held between requests
  always @(posedge ref_clk_i) begin
    cap_pin_o <= lvl_i;
  end
  // Count level changes seen on channel two
  always @(posedge ref_clk_i) begin
    prev_q <= cmp_pin_i[3];
    if (cmp_pin_i[3] != prev_q) begin
      tog_cnt_o <= tog_cnt_o + 8'h01;
    end
  end
endmodule // tcf_pin_model

// ==== verification/tcf_timer_asserts.sv ====
module tcf_timer_asserts import tcf_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bus side
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Timer side
  input wire logic [15:0] cmp1_val_i,
  input wire logic [15:0] cmp2_val_i,
  input wire logic [15:0] cmp4_val_i,
  input wire logic [3:0] cmp_pin_o,
  input wire logic [3:0] cmp_pin_oe_o,
  input wire logic [15:0] count_o,
  input wire logic cmp1_match_o,
  input wire logic [3:0] accum_ctrl_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Bus handshake
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // Counter, compare and control-bit timing
  cnt_step_a: assert property (!$stable(count_o) |-> count_o == $past(count_o) + 16'h0001)
    else $error("counter jumped");
  match_cnt_a: assert property (cmp1_match_o |-> count_o == cmp1_val_i)
    else $error("channel one match at wrong count");
  pin_two_a: assert property ($changed(cmp_pin_o[3]) |-> count_o == cmp2_val_i)
    else $error("channel two pin moved off match");
  pin_four_a: assert property ($changed(cmp_pin_o[1]) |-> count_o == cmp4_val_i)
    else $error("channel four pin moved off match");
  oe_write_a: assert property ($changed(cmp_pin_oe_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("pin enable changed without write");
  actl_write_a: assert property ($changed(accum_ctrl_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("control bits changed without write");
  // Main scenarios reached
  match_c: cover property (cmp1_match_o);
  irq_c: cover property ($rose(irq_o));
  write_c: cover property (wb_ack_o && wb_we_i);
endmodule // tcf_timer_asserts

bind tcf_timer tcf_timer_asserts u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp1_val_i(cmp1_val_i),
  .cmp2_val_i(cmp2_val_i), .cmp4_val_i(cmp4_val_i), .cmp_pin_o(cmp_pin_o),
  .cmp_pin_oe_o(cmp_pin_oe_o), .count_o(count_o), .cmp1_match_o(cmp1_match_o),
  .accum_ctrl_o(accum_ctrl_o), .irq_o(irq_o)
);

// ==== verification/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcf_pkg::*;
  localparam int PL = 3;
  // Inputs of the block, all defined at time zero
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [15:0] cv [1:5] = '{default: 16'hFFFF};
  logic [7:0] esel = 8'h00;
  logic aovf = 1'b0;
  logic aedge = 1'b0;
  logic spec = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [31:0] rdat;
  logic ack, m1, pa3, irq;
  logic [3:0] cpin, coe, cap, actl;
  logic [15:0] cnt;
  logic [7:0] tog;
  int fails = 0;
  int check_count = 0;
  int cyc_no = 0;
  // Clock and cycle count
  always #4 clk = ~clk;
  always @(posedge clk) cyc_no <= cyc_no + 1;
  tcf_timer #(.PER_LOG2(PL)) u_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .special_mode_i(spec), .cmp1_val_i(cv[1]), .cmp2_val_i(cv[2]), .cmp3_val_i(cv[3]),
    .cmp4_val_i(cv[4]), .cmp5_val_i(cv[5]), .cap_pin_i(cap), .cap_edge_sel_i(esel),
    .accum_ovf_evt_i(aovf), .accum_edge_evt_i(aedge), .cmp_pin_o(cpin),
    .cmp_pin_oe_o(coe), .count_o(cnt), .cmp1_match_o(m1), .accum_ctrl_o(actl),
    .porta3_dir_o(pa3), .irq_o(irq));
  tcf_pin_model u_pins (
    .ref_clk_i(clk), .lvl_i(lvl), .cap_pin_o(cap), .cmp_pin_i(cpin), .tog_cnt_o(tog));
  // ****************************************
  // Checking and bus helpers
  // ****************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic to_out(input string nm);
    fails++;
    $display("[FAIL] %s expected done seen timeout", nm);
    wrap_up();
  endtask
  // Kind 1 waits on the request line, otherwise on the counter copy
  task automatic wait_on(input int k, input logic [15:0] v, input int lim);
    int n;
    n = 0;
    while ((k == 1 ? {15'h0000, irq} : cnt) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) to_out("wait");
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) to_out("bus ack");
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_presc();
    logic [15:0] c0;
    wr(OFS_IRQ_EN2, 8'hFC);
    rd(OFS_IRQ_EN2, 8'hF0);
    wr(OFS_IRQ_EN2, 8'h03);
    rd(OFS_IRQ_EN2, 8'h00);
    c0 = cnt;
    repeat (64) @(posedge clk);
    chk("count step", c0 + 16'h0040, cnt);
  endtask
  task automatic t_reset();
    logic [7:0] ofs [5] = '{OFS_PIN_ACT, OFS_IRQ_EN1, OFS_FLAGS1, OFS_ACC_CTRL, 8'h1C};
    foreach (ofs[i]) rd(ofs[i], 8'h00);
  endtask
  task automatic t_cmp();
    logic [15:0] t;
    t = cnt + 16'h0040;
    for (int i = 1; i <= 5; i++) cv[i] <= t + 16'(i);
    wr(OFS_PIN_ACT, 8'h6C);
    wr(OFS_IRQ_EN1, 8'h80);
    wait_on(0, t + 16'h0001, 300);
    chk("match pulse", 16'h0001, {15'h0000, m1});
    wait_on(0, t + 16'h0008, 20);
    chk("pins", 16'h000A, {12'h000, cpin});
    chk("pin enables", 16'h000E, {12'h000, coe});
    chk("irq cmp1", 16'h0001, {15'h0000, irq});
    rd(OFS_FLAGS1, 8'hF8);
    wr(OFS_FLAGS1, 8'h40);
    rd(OFS_FLAGS1, 8'hB8);
    wr(OFS_FLAGS1, 8'hFF);
    rd(OFS_FLAGS1, 8'h00);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
  endtask
  task automatic t_cap();
    wr(OFS_ACC_CTRL, 8'hAC);
    rd(OFS_ACC_CTRL, 8'hAC);
    chk("acc ctrl", 16'h000A, {12'h000, actl});
    chk("dir bit", 16'h0001, {15'h0000, pa3});
    wr(OFS_IRQ_EN1, 8'h08);
    esel <= 8'h6C;
    lvl <= 4'hF;
    repeat (10) @(posedge clk);
    rd(OFS_FLAGS1, 8'h05);
    lvl <= 4'h0;
    repeat (10) @(posedge clk);
    rd(OFS_FLAGS1, 8'h07);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    esel <= 8'h6D;
    lvl <= 4'h1;
    repeat (10) @(posedge clk);
    rd(OFS_FLAGS1, 8'h0F);
    chk("irq shared", 16'h0001, {15'h0000, irq});
    wr(OFS_FLAGS1, 8'hFF);
  endtask
  // Clear the periodic flag, then time the next rise of the request
  task automatic per_edge(output int t);
    wr(OFS_FLAGS2, 8'h40);
    wait_on(1, 16'h0000, 300);
    wait_on(1, 16'h0001, 300);
    t = cyc_no;
  endtask
  task automatic t_per();
    int t1, t2;
    wr(OFS_IRQ_EN1, 8'h00);
    wr(OFS_IRQ_EN2, 8'h40);
    wr(OFS_ACC_CTRL, 8'h03);
    per_edge(t1);
    per_edge(t2);
    chk("period", 16'(1 << (PL + 3)), 16'(t2 - t1));
  endtask
  task automatic t_ovf();
    wr(OFS_IRQ_EN2, 8'h80);
    wr(OFS_FLAGS2, 8'hFF);
    wait_on(0, 16'hFFFF, 70000);
    wait_on(1, 16'h0001, 4);
    aovf <= 1'b1;
    aedge <= 1'b1;
    @(posedge clk);
    aovf <= 1'b0;
    aedge <= 1'b0;
    @(posedge clk);
    rd(OFS_FLAGS2, 8'hF0);
    wr(OFS_FLAGS2, 8'h30);
    rd(OFS_FLAGS2, 8'hC0);
    wr(OFS_IRQ_EN2, 8'h00);
    rd(OFS_IRQ_EN2, 8'h00);
    chk("irq suppressed", 16'h0000, {15'h0000, irq});
    wait_on(0, cv[2] + 16'h0004, 300);
    chk("ch2 toggles", 16'h0002, {8'h00, tog});
  endtask
  // Mid-run reset: registers clear, prescale window closes unused
  task automatic t_rst2();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_FLAGS2, 8'h00);
    rd(OFS_FLAGS1, 8'h00);
    rd(OFS_PIN_ACT, 8'h00);
    repeat (70) @(posedge clk);
    wr(OFS_IRQ_EN2, 8'h03);
    rd(OFS_IRQ_EN2, 8'h00);
  endtask
  // Special mode lets the prescale bits change; steps over 64 cycles
  task automatic t_spec();
    logic [15:0] c0;
    logic [15:0] stp [1:3] = '{16'h0010, 16'h0008, 16'h0004};
    spec <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wr(OFS_IRQ_EN2, 8'(s));
      rd(OFS_IRQ_EN2, 8'(s));
      repeat (16) @(posedge clk);
      c0 = cnt;
      repeat (64) @(posedge clk);
      chk("prescaled step", c0 + stp[s], cnt);
    end
    spec <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_presc();
    t_reset();
    t_cmp();
    t_cap();
    t_per();
    t_ovf();
    t_rst2();
    t_spec();
    wrap_up();
  end
endmodule // testbench
